// >>> src/tps_consts.svh
// How it works
// (R1) Unit 1 trigger select at bits 19:16
// (R2) Trigger code 0001 acts as 0000
// (R3) Unit 0 trigger select at bits 15:12
// (R4) Channel 1 index select, bits 11:10
// (R5) Channel 1 phase B select, bits 9:8
// (R6) Channel 1 phase A select, bits 7:6
// (R7) Channel 0 index select, bits 5:4
// (R8) Channel 0 phase B select, bits 3:2
// (R9) Channel 0 phase A select, bits 1:0
// (R10) Reads return written codes, not routing
// (R11) Select register survives deep standby reset
// (R12) Address enables bits 31:16, reset zero
// (R13) Variants: no bit 2, or no register
// (R14) Enable set drives line, clear drives nothing
// (R15) Fields steer muxes straight after write
// (R16) Lower enable bits gate pins likewise
`ifndef TPS_CONSTS_SVH
`define TPS_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TPS_OFF_SEL      12'h000
`define TPS_OFF_PIN      12'h004
`define TPS_DEC_W        12

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define TPS_CONV0_LSB    12
`define TPS_CONV1_LSB    16
`define TPS_CONV_W       4
`define TPS_CONV_PINS    9
`define TPS_CNT_LSB      0
`define TPS_CNT_W        2
`define TPS_CNT_PINS     3
`define TPS_CNT_FIELDS   6
`define TPS_PIN_BIT2     2

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define TPS_SEL_RST      32'h0000_0000
`define TPS_PIN_RST      32'h0000_0000
`define TPS_SEL_MASK     32'h000f_ffff
`define TPS_PIN_MASK     32'hffff_ffff
`define TPS_BIT2_MASK    32'hffff_fffb

`endif

// >>> src/tps_field_mux.sv
`timescale 1ns/1ps
`default_nettype none
// Routes one of N pins by a select code; codes 0 and 1 both pick pin 0,
// code k above 1 picks pin k-1, anything past the last pin falls back to 0.
module tps_field_mux
    import tps_pkg::*;
#(
    parameter int W = 2,
    parameter int N = 3
) (
    // Select code and candidate pins
    input  wire logic [W-1:0] code,
    input  wire logic [N-1:0] pins,
    // Routed level
    output logic              routed
);
    // Shared decode for both the trigger and counter encodings
    localparam logic [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
    localparam logic [W-1:0] LAST = W'(N);

    wire logic [W-1:0] dec_idx;   // Pin index for codes above 1
    wire logic         in_range;  // Code names a real pin above 0

    assign dec_idx  = code - ONE;
    // Prohibited codes land on pin 0 so the input is never left floating
    assign in_range = (code > ONE) && (dec_idx < LAST);              // R2
    assign routed   = in_range ? pins[dec_idx] : pins[0];            // R15
endmodule
`default_nettype wire

// >>> src/tps_pkg.sv
package tps_pkg;
    // Bus data word
    typedef logic [31:0] tps_word_type;
    // AHB transfer kinds
    typedef enum logic [1:0] {
        TPS_HT_IDLE   = 2'h0,
        TPS_HT_BUSY   = 2'h1,
        TPS_HT_NONSEQ = 2'h2,
        TPS_HT_SEQ    = 2'h3
    } tps_htrans_type;
    // Register targeted by a data phase, one-hot
    typedef enum logic [2:0] {
        TPS_REG_NONE = 3'b001,
        TPS_REG_SEL  = 3'b010,
        TPS_REG_PIN  = 3'b100
    } tps_reg_type;
endpackage

// >>> src/tps_top.sv
`timescale 1ns/1ps
`default_nettype none
module tps_top
    import tps_pkg::*;
#(
    parameter bit HAS_PIN_REG = 1'b1,  // Product carries the bus pin register
    parameter bit HAS_BIT2    = 1'b1   // Product carries enable bit 2
) (
    // Clock and resets
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        sel_rstn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Converter trigger pins and routed triggers
    input  wire logic [8:0]  conv_trig_pin,
    output logic             conv0_trig,
    output logic             conv1_trig,
    // Counter pin options
    input  wire logic [2:0]  cnt0_phase_a_pin,
    input  wire logic [2:0]  cnt0_phase_b_pin,
    input  wire logic [2:0]  cnt0_index_pin,
    input  wire logic [2:0]  cnt1_phase_a_pin,
    input  wire logic [2:0]  cnt1_phase_b_pin,
    input  wire logic [2:0]  cnt1_index_pin,
    // Counter routed inputs
    output logic             cnt0_phase_a,
    output logic             cnt0_phase_b,
    output logic             cnt0_index,
    output logic             cnt1_phase_a,
    output logic             cnt1_phase_b,
    output logic             cnt1_index,
    // External bus lines and their pins
    input  wire logic [31:0] ext_bus_line,
    output logic [31:0]      ext_pin_out,
    output logic [31:0]      ext_pin_oe
);
`include "tps_consts.svh"

    // ----------------------------------------
    // Bus address phase
    // ----------------------------------------
    wire logic                 addr_take;   // Valid transfer accepted
    wire logic [`TPS_DEC_W-1:0] addr_off;   // Offset inside our window
    wire logic                 hit_sel;     // Select register addressed
    wire logic                 hit_pin;     // Pin register addressed
    tps_reg_type               reg_d;       // Target of the next data phase
    tps_reg_type               reg_q;       // Target of the current data phase
    logic                      wr_q;        // Current data phase is a write
    logic                      hready_q;    // Registered ready
    logic                      hresp_q;     // Registered response
    tps_word_type              rdata_q;     // Registered read data

    // Only NONSEQ and SEQ carry a transfer; IDLE and BUSY are ignored
    assign addr_take = hsel && hready &&
                       ((htrans == TPS_HT_NONSEQ) || (htrans == TPS_HT_SEQ));
    assign addr_off  = haddr[`TPS_DEC_W-1:0];
    // Upper address bits are decoded by the fabric, word alignment here
    assign hit_sel   = (addr_off == `TPS_OFF_SEL);
    assign hit_pin   = (addr_off == `TPS_OFF_PIN) && HAS_PIN_REG;     // R13

    // Unmapped offsets still answer OKAY, reading zero and dropping writes
    always_comb begin
        reg_d = TPS_REG_NONE;
        if (addr_take && hit_sel) begin
            reg_d = TPS_REG_SEL;
        end else if (addr_take && hit_pin) begin
            reg_d = TPS_REG_PIN;
        end
    end

    // ----------------------------------------
    // Register next values
    // ----------------------------------------
    tps_word_type              sel_q;       // Input select register
    tps_word_type              pin_q;       // Bus pin enable register
    tps_word_type              sel_d;
    tps_word_type              pin_d;
    wire tps_word_type         pin_mask;    // Bits that exist in this product
    wire logic                 wr_sel;      // Write data phase to select
    wire logic                 wr_pin;      // Write data phase to pin enables

    assign pin_mask = HAS_BIT2 ? `TPS_PIN_MASK : `TPS_BIT2_MASK;     // R13
    assign wr_sel   = wr_q && (reg_q == TPS_REG_SEL);
    assign wr_pin   = wr_q && (reg_q == TPS_REG_PIN);

    // Raw code is stored, aliases included, so readback shows what was written
    assign sel_d = wr_sel ? (hwdata & `TPS_SEL_MASK) : sel_q;         // R10
    // Absent bits read zero and ignore writes
    assign pin_d = wr_pin ? (hwdata & pin_mask) : pin_q;              // R16

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    tps_word_type              rdata_d;     // Read word for an accepted read

    // Reading from the next values keeps a read right after a write coherent
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (addr_take && !hwrite && hit_sel) begin
            rdata_d = sel_d;                                          // R10
        end else if (addr_take && !hwrite && hit_pin) begin
            rdata_d = pin_d;
        end
    end

    // ----------------------------------------
    // Bus state flops
    // ----------------------------------------
    // Zero wait states: the slave never stretches a transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_q    <= TPS_REG_NONE;
            wr_q     <= 1'b0;
            hready_q <= 1'b1;
            hresp_q  <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            reg_q    <= reg_d;
            wr_q     <= addr_take && hwrite;
            hready_q <= 1'b1;
            hresp_q  <= 1'b0;
            rdata_q  <= rdata_d;
        end
    end

    assign hrdata    = rdata_q;
    assign hreadyout = hready_q;
    assign hresp     = hresp_q;

    // ----------------------------------------
    // Select register
    // ----------------------------------------
    // Cleared only by the non-standby reset, so a deep standby return keeps it
    always_ff @(posedge hclk or negedge sel_rstn) begin
        if (!sel_rstn) begin
            sel_q <= `TPS_SEL_RST;                                    // R11
        end else if (hresetn) begin
            sel_q <= sel_d;                                           // R1 R3
        end
    end

    // ----------------------------------------
    // Bus pin enable register
    // ----------------------------------------
    // Only hresetn clears the enables, in full and standby reset alike; sel_rstn alone does not; pins go quiet
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_q <= `TPS_PIN_RST;                                    // R12
        end else begin
            pin_q <= pin_d;                                           // R12
        end
    end

    // ----------------------------------------
    // Converter trigger routing
    // ----------------------------------------
    wire logic [1:0]           conv_routed; // Mux outputs per unit
    logic [1:0]                conv_q;      // Registered triggers

    // One mux per converter unit; same encoding, fields four bits apart
    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_conv
            tps_field_mux #(
                .W (`TPS_CONV_W),
                .N (`TPS_CONV_PINS)
            ) u_mux (
                .code   (sel_q[`TPS_CONV0_LSB + gc*`TPS_CONV_W +: `TPS_CONV_W]),
                .pins   (conv_trig_pin),
                .routed (conv_routed[gc])
            );                                                        // R1 R3
        end
    endgenerate

    // Registered so the triggers leave from flops; costs one cycle of delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_q <= 2'h0;
        end else begin
            conv_q <= conv_routed;                                    // R15
        end
    end

    assign conv0_trig = conv_q[0];
    assign conv1_trig = conv_q[1];

    // ----------------------------------------
    // Counter input routing
    // ----------------------------------------
    wire logic [2:0]           cnt_pins [`TPS_CNT_FIELDS]; // Options per field
    wire logic [5:0]           cnt_routed;  // Mux outputs per field
    logic [5:0]                cnt_q;       // Registered counter inputs

    // Field order follows the bit order, lowest field first
    assign cnt_pins[0] = cnt0_phase_a_pin;
    assign cnt_pins[1] = cnt0_phase_b_pin;
    assign cnt_pins[2] = cnt0_index_pin;
    assign cnt_pins[3] = cnt1_phase_a_pin;
    assign cnt_pins[4] = cnt1_phase_b_pin;
    assign cnt_pins[5] = cnt1_index_pin;

    genvar gq;
    generate
        for (gq = 0; gq < `TPS_CNT_FIELDS; gq++) begin : g_cnt
            tps_field_mux #(
                .W (`TPS_CNT_W),
                .N (`TPS_CNT_PINS)
            ) u_mux (
                .code   (sel_q[`TPS_CNT_LSB + gq*`TPS_CNT_W +: `TPS_CNT_W]),
                .pins   (cnt_pins[gq]),
                .routed (cnt_routed[gq])
            );                                       // R4 R5 R6 R7 R8 R9
        end
    endgenerate

    // Same one-cycle registration as the triggers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_routed;                                      // R15
        end
    end

    assign cnt0_phase_a = cnt_q[0];
    assign cnt0_phase_b = cnt_q[1];
    assign cnt0_index   = cnt_q[2];
    assign cnt1_phase_a = cnt_q[3];
    assign cnt1_phase_b = cnt_q[4];
    assign cnt1_index   = cnt_q[5];

    // ----------------------------------------
    // External bus pin gating
    // ----------------------------------------
    logic [31:0]               pin_out_q;   // Gated line levels
    logic [31:0]               pin_oe_q;    // Pin drive enables

    // A cleared enable leaves the pin undriven and its level at zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out_q <= 32'h0000_0000;
            pin_oe_q  <= 32'h0000_0000;
        end else begin
            pin_out_q <= ext_bus_line & pin_q;                        // R14 R16
            pin_oe_q  <= pin_q;                                       // R14 R16
        end
    end

    assign ext_pin_out = pin_out_q;
    assign ext_pin_oe  = pin_oe_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Zero wait state and OKAY hold throughout
    a_bus_okay_ready: assert property (
        hreadyout && !hresp
    ) else $error("slave stretched or errored a transfer");

    // A written select word is stored with bits 31:20 dropped and read back as stored
    a_sel_wr_rd: assert property ( // R10
        (addr_take && hwrite && hit_sel) ##1 1'b1 |=>
            (sel_q == ($past(hwdata) & `TPS_SEL_MASK))
    ) else $error("select register did not store written code");

    a_sel_read_back: assert property ( // R10
        (addr_take && !hwrite && hit_sel && !wr_q) |=> (hrdata == sel_q)
    ) else $error("select readback differs from stored code");

    // Unit 1 trigger follows its code one edge later
    // History from inside reset is not judged: outputs were cleared there
    a_conv1_route: assert property ( // R1
        ($past(hresetn) && $past(sel_q[19:16]) > 4'h1 && $past(sel_q[19:16]) < 4'ha)
            |-> (conv1_trig ==
                 |(({$past(conv_trig_pin), 1'b0} >> $past(sel_q[19:16])) & 10'h001))
    ) else $error("unit 1 trigger routed from wrong pin");

    // Alias codes pick pin 0 for unit 0
    a_conv_alias: assert property ( // R2
        ($past(hresetn) && $past(sel_q[15:12]) <= 4'h1)
            |-> (conv0_trig == $past(conv_trig_pin[0]))
    ) else $error("unit 0 alias code did not route pin 0");

    a_conv0_route: assert property ( // R3
        ($past(hresetn) && $past(sel_q[15:12]) > 4'h1 && $past(sel_q[15:12]) < 4'ha)
            |-> (conv0_trig ==
                 |(({$past(conv_trig_pin), 1'b0} >> $past(sel_q[15:12])) & 10'h001))
    ) else $error("unit 0 trigger routed from wrong pin");

    // Channel 0 phase A on code 3 takes option 2
    a_cnt_opt_two: assert property ( // R9
        ($past(hresetn) && $past(sel_q[1:0]) == 2'h3)
            |-> (cnt0_phase_a == $past(cnt0_phase_a_pin[2]))
    ) else $error("phase A option 2 not routed");

    // Channel 1 index on code 2 takes option 1
    a_cnt_idx_route: assert property ( // R4
        ($past(hresetn) && $past(sel_q[11:10]) == 2'h2)
            |-> (cnt1_index == $past(cnt1_index_pin[1]))
    ) else $error("channel 1 index option 1 not routed");

    // Deep standby reset alone leaves the select codes untouched
    a_sel_keep_stby: assert property ( // R11
        @(posedge hclk) disable iff (!sel_rstn) (!hresetn) |=> $stable(sel_q)
    ) else $error("select register lost contents in deep standby reset");

    // Select fields start at zero after a full reset
    a_sel_reset_zero: assert property ( // R11
        @(posedge hclk) disable iff (!hresetn) $rose(sel_rstn) |-> (sel_q == `TPS_SEL_RST)
    ) else $error("select fields not zero after reset");

    // Enables start cleared after release
    a_pin_reset_zero: assert property ( // R12
        $rose(hresetn) |-> (pin_q == `TPS_PIN_RST) && (ext_pin_oe == 32'h0000_0000)
    ) else $error("pin enables not cleared by reset");

    // Missing bit 2 never turns on
    a_pin_bit2_gone: assert property ( // R13
        (!HAS_BIT2 || !HAS_PIN_REG) |-> !pin_q[`TPS_PIN_BIT2]
    ) else $error("absent enable bit became set");

    // Pin drive follows its enable one edge later
    a_pin_gating: assert property ( // R14
        ##1 (ext_pin_oe == $past(pin_q)) &&
            (ext_pin_out == ($past(ext_bus_line) & $past(pin_q)))
    ) else $error("pin drive does not follow its enable");

    // Main scenarios
    c_sel_write:  cover property (addr_take && hwrite && hit_sel);
    c_pin_read:   cover property (addr_take && !hwrite && hit_pin);
    c_conv_last:  cover property (sel_q[19:16] == 4'h9);
    c_pin_driven: cover property (ext_pin_oe != 32'h0000_0000);

    // Transfer size is not checked: only whole-word accesses are expected
    wire logic unused_size;
    assign unused_size = ^hsize;
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tps_consts.svh"
module tb
    import tps_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        hclk;
    logic        hresetn;
    logic        sel_rstn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [8:0]  conv_pins;
    logic [2:0]  cnt_pins;
    logic [31:0] bus_lines;
    logic        conv0_trig;
    logic        conv1_trig;
    wire logic [5:0] cnt_route; // Field order, channel 0 phase A first
    logic [31:0] ext_pin_out;
    logic [31:0] ext_pin_oe;
    logic [3:0]  conv_hot;
    logic [1:0]  cnt_hot;
    logic        inv;
    int          err_total;
    int          compares;

    // ----------------------------------------
    // Instances
    // ----------------------------------------
    tps_pin_model pins (.conv_hot(conv_hot), .cnt_hot(cnt_hot), .inv(inv),
        .conv_pins(conv_pins), .cnt_pins(cnt_pins), .bus_lines(bus_lines));

    // Variant without enable bit 2, so its absence is exercised
    tps_top #(.HAS_BIT2(1'b0)) DUT (.hclk(hclk), .hresetn(hresetn), .sel_rstn(sel_rstn),
        .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .conv_trig_pin(conv_pins),
        .conv0_trig(conv0_trig), .conv1_trig(conv1_trig),
        .cnt0_phase_a_pin(cnt_pins), .cnt0_phase_b_pin(cnt_pins),
        .cnt0_index_pin(cnt_pins), .cnt1_phase_a_pin(cnt_pins),
        .cnt1_phase_b_pin(cnt_pins), .cnt1_index_pin(cnt_pins),
        .cnt0_phase_a(cnt_route[0]), .cnt0_phase_b(cnt_route[1]),
        .cnt0_index(cnt_route[2]), .cnt1_phase_a(cnt_route[3]),
        .cnt1_phase_b(cnt_route[4]), .cnt1_index(cnt_route[5]),
        .ext_bus_line(bus_lines), .ext_pin_out(ext_pin_out), .ext_pin_oe(ext_pin_oe));

    // Free-running bus clock
    always #5 hclk = ~hclk;

    // ----------------------------------------
    // Compare and bus helpers
    // ----------------------------------------
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single transfer; waits on hready, no assumed latency
    task automatic bus_xfer(input logic wr, input logic [11:0] off,
                            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= TPS_HT_NONSEQ;
        haddr  <= {20'h0, off};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        // Address phase taken, data phase follows
        hsel   <= 1'b0;
        htrans <= TPS_HT_IDLE;
        hwdata <= wr ? wd : 32'h0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        cmp1(hresp, 1'b0);
    endtask

    task automatic reg_wr(input logic [11:0] off, input logic [31:0] wd);
        logic [31:0] unused;
        bus_xfer(1'b1, off, wd, unused);
    endtask

    task automatic reg_chk(input logic [11:0] off, input logic [31:0] exp);
        logic [31:0] rd;
        bus_xfer(1'b0, off, 32'h0, rd);
        cmp32(rd, exp);
    endtask

    // Outputs are registered: two edges let a pin change land
    task automatic drive_pins(input int ch, input int kh, input logic iv);
        @(posedge hclk);
        conv_hot <= ch[3:0];
        cnt_hot  <= kh[1:0];
        inv      <= iv;
        repeat (2) @(posedge hclk);
        #1;
    endtask

    // Both low is a full reset; hresetn alone is the standby return
    task automatic pulse_reset(input logic keep_sel);
        @(posedge hclk);
        hresetn  <= 1'b0;
        sel_rstn <= keep_sel;
        repeat (5) @(posedge hclk);
        hresetn  <= 1'b1;
        sel_rstn <= 1'b1;
        @(posedge hclk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        reg_chk(`TPS_OFF_SEL, 32'h0);
        reg_chk(`TPS_OFF_PIN, 32'h0);
        drive_pins(0, 0, 1'b0);
        cmp1(conv0_trig, 1'b1);
        cmp1(conv1_trig, 1'b1);
        cmp32({26'h0, cnt_route}, 32'h3f);
        cmp32(ext_pin_oe, 32'h0);
        $display("reset values done");
    endtask

    // Units get mirrored codes so every code 0 to 9 meets both fields
    task automatic test_conv_route();
        logic [3:0] c1;
        logic [3:0] c0;
        int         p1;
        int         p0;
        for (int c = 0; c < 10; c++) begin
            c1 = c[3:0];
            c0 = 4'(9 - c);
            p1 = (c1 < 2) ? 0 : c1 - 1;
            p0 = (c0 < 2) ? 0 : c0 - 1;
            reg_wr(`TPS_OFF_SEL, {12'h0, c1, c0, 12'h0});
            reg_chk(`TPS_OFF_SEL, {12'h0, c1, c0, 12'h0});
            for (int h = 0; h < 9; h++) begin
                drive_pins(h, 0, 1'b0);
                cmp1(conv1_trig, 1'(h == p1));
                cmp1(conv0_trig, 1'(h == p0));
            end
            drive_pins(p1, 0, 1'b1);
            cmp1(conv1_trig, 1'b0);
        end
        $display("converter trigger routing done");
    endtask

    // Field k gets code c+k modulo 4, so adjacent fields differ and a swapped field shows
    task automatic test_cnt_route();
        logic [11:0] val;
        logic [1:0]  code;
        int          opt;
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < 6; k++) val[2*k +: 2] = 2'(c + k);
            reg_wr(`TPS_OFF_SEL, {20'h0, val});
            reg_chk(`TPS_OFF_SEL, {20'h0, val});
            for (int h = 0; h < 3; h++) begin
                drive_pins(0, h, 1'b0);
                for (int k = 0; k < 6; k++) begin
                    code = val[2*k +: 2];
                    opt  = (code < 2) ? 0 : code - 1;
                    cmp1(cnt_route[k], 1'(h == opt));
                end
            end
        end
        $display("counter input routing done");
    endtask

    // Unimplemented select bits and an unmapped word
    task automatic test_reg_map();
        reg_wr(`TPS_OFF_SEL, 32'hffff_ffff);
        reg_chk(`TPS_OFF_SEL, 32'h000f_ffff);
        reg_wr(12'h008, 32'h1234_5678);
        reg_chk(12'h008, 32'h0);
        reg_chk(`TPS_OFF_SEL, 32'h000f_ffff);
        $display("register map done");
    endtask

    task automatic test_pin_enable();
        logic [31:0] pats [3] = '{32'hffff_0000, 32'h0000_ffff, 32'h8001_0004};
        foreach (pats[i]) begin
            reg_wr(`TPS_OFF_PIN, pats[i]);
            reg_chk(`TPS_OFF_PIN, pats[i] & `TPS_BIT2_MASK);
            drive_pins(0, 0, i[0]);
            cmp32(ext_pin_oe, pats[i] & `TPS_BIT2_MASK);
            cmp32(ext_pin_out, bus_lines & pats[i] & `TPS_BIT2_MASK);
        end
        $display("bus pin enables done");
    endtask

    task automatic test_standby();
        reg_wr(`TPS_OFF_SEL, 32'h0009_5e1b);
        reg_wr(`TPS_OFF_PIN, 32'hffff_ffff);
        pulse_reset(1'b1);
        reg_chk(`TPS_OFF_SEL, 32'h0009_5e1b);
        reg_chk(`TPS_OFF_PIN, 32'h0);
        cmp32(ext_pin_oe, 32'h0);
        pulse_reset(1'b0);
        reg_chk(`TPS_OFF_SEL, 32'h0);
        $display("standby reset done");
    endtask

    // ----------------------------------------
    // Verdict and main sequence
    // ----------------------------------------
    task automatic finish_test();
        $display("Counts: compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        hclk      = 1'b0;
        hresetn   = 1'b0;
        sel_rstn  = 1'b0;
        hsel      = 1'b0;
        haddr     = 32'h0;
        htrans    = TPS_HT_IDLE;
        hwrite    = 1'b0;
        hsize     = 3'h2;
        hwdata    = 32'h0;
        conv_hot  = 4'h0;
        cnt_hot   = 2'h0;
        inv       = 1'b0;
        err_total = 0;
        compares  = 0;
        repeat (5) @(posedge hclk);
        hresetn  <= 1'b1;
        sel_rstn <= 1'b1;
        test_reset();
        test_conv_route();
        test_cnt_route();
        test_reg_map();
        test_pin_enable();
        test_standby();
        finish_test();
    end

    // Whole run needs about 500 cycles; this is far beyond
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire

// >>> testbench/tps_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far-side pins and bus-controller lines
// ----------------------------------------
module tps_pin_model (
    // Bench control
    input  wire logic [3:0]  conv_hot,
    input  wire logic [1:0]  cnt_hot,
    input  wire logic        inv,
    // Levels toward the block
    output logic [8:0]       conv_pins,
    output logic [2:0]       cnt_pins,
    output logic [31:0]      bus_lines
);
    // A lone differing pin turns a wrong route into a wrong level
    assign conv_pins = (9'h001 << conv_hot) ^ {9{inv}};
    // Same option pattern on all six counter groups
    assign cnt_pins  = (3'h1 << cnt_hot) ^ {3{inv}};
    // Lines flip as a whole so gating is seen in both polarities
    assign bus_lines = inv ? 32'h5a5a_c3c3 : 32'ha5a5_3c3c;
endmodule
`default_nettype wire
